// ===== rtl/sra_service_request.sv
// Service request and acknowledge logic with Avalon-MM registers and context stack.
// Operation
// - each level drives its own request pin
// - auto priority picks level at acknowledge
// - acknowledge address compared with three match values
// - no match means no strobe, no action
// - acknowledge register read acts as acknowledge
// - pending level keeps acknowledge, drives vector
// - vector holds type low, host bits high
// - idle level passes matching acknowledge down chain
// - grant pushes type and channel on stack
// - end-of-service write pops the stack
// - pending request returns two clocks after pop
// - stack holds three contexts
// - stack readable in service status register
// - channel register read masks channel into 4:2
// - without context, channel comes from access register
// - hold request while shared line driven elsewhere
// - ack states held while acknowledge present
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/1ns
module sra_service_request (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic post_valid,
  input wire logic [1:0] post_level,
  input wire logic [2:0] post_type,
  input wire logic [2:0] post_channel,
  output logic post_ready,
  output logic receive_service_request_n,
  output logic transmit_service_request_n,
  output logic modem_change_request_n,
  input wire logic [2:0] ext_request_n,
  input wire logic chain_ack_in_n,
  input wire logic [7:0] ack_address,
  output logic chain_ack_out_n,
  output logic data_transfer_ack_n,
  output logic [7:0] ack_data,
  output logic [2:0] active_channel
);
  localparam int NL = sra_pkg::NUM_LEVELS;
  localparam int SD = sra_pkg::STACK_DEPTH;

  sra_pkg::sra_bus_state_t bus_reg, bus_next;
  logic [31:0] rdata_reg, rdata_next, rd_val;
  logic [1:0] soft_lvl_reg, soft_lvl_next;
  logic automatic_priority_reg, automatic_priority_next;
  logic [4:0] vec_upper_reg, vec_upper_next;
  logic [7:0] match_reg [NL];
  logic [7:0] match_next [NL];
  logic [7:0] chan_store_reg [NL];
  logic [7:0] chan_store_next [NL];
  logic [2:0] car_reg, car_next;
  logic [NL-1:0] pending_reg, pending_next;
  logic [2:0] pend_type_reg [NL];
  logic [2:0] pend_type_next [NL];
  logic [2:0] pend_chan_reg [NL];
  logic [2:0] pend_chan_next [NL];
  logic [1:0] stk_lvl_reg [SD];
  logic [1:0] stk_lvl_next [SD];
  logic [2:0] stk_type_reg [SD];
  logic [2:0] stk_type_next [SD];
  logic [2:0] stk_chan_reg [SD];
  logic [2:0] stk_chan_next [SD];
  logic [1:0] depth_reg, depth_next, d;
  logic [7:0] ack_data_reg, ack_data_next;
  logic data_transfer_ack_n_n_reg, data_transfer_ack_n_n_next;
  logic [NL-1:0] match_hit, ack_hit, chan_hit, addr_match, raw_match, eff_match;
  logic [NL-1:0] req_n, grant, in_req, passing, keeping, internal_req, in_service;
  logic [1:0] hit_idx, top_idx, grant_lvl;
  logic [2:0] top_type, grant_type;
  logic [7:0] vec_now;
  logic hw_ack, soft_ack, ack_active, eos_pop, any_hold;

  // Address decode of the per-level register groups.
  always_comb begin
    match_hit = '0;
    ack_hit = '0;
    chan_hit = '0;
    hit_idx = 2'h0;
    for (int l = 0; l < NL; l++) begin
      match_hit[l] = (avs_address == sra_pkg::OFF_MATCH_BASE + 8'(l * 4));
      ack_hit[l] = (avs_address == sra_pkg::OFF_ACK_BASE + 8'(l * 4));
      chan_hit[l] = (avs_address == sra_pkg::OFF_CHANNEL_BASE + 8'(l * 4));
      if (match_hit[l] || ack_hit[l] || chan_hit[l]) begin
        hit_idx = 2'(l);
      end
    end
  end

  // Stack top, active channel and the vector now on offer.
  always_comb begin
    top_idx = depth_reg - 2'h1;
    top_type = (depth_reg != 2'h0) ? stk_type_reg[top_idx] : 3'h0;
    active_channel = (depth_reg != 2'h0) ? stk_chan_reg[top_idx] : car_reg;
    vec_now = {vec_upper_reg, top_type};
    in_service = '0;
    for (int i = 0; i < SD; i++) begin
      if (2'(i) < depth_reg) begin
        in_service[stk_lvl_reg[i]] = 1'b1;
      end
    end
  end

  // Acknowledge sources and the level that each acknowledge selects.
  always_comb begin
    hw_ack = !chain_ack_in_n;
    soft_ack = (bus_reg == sra_pkg::BUS_ACK);
    ack_active = hw_ack || soft_ack;
    any_hold = (passing != '0) || (keeping != '0);
    for (int l = 0; l < NL; l++) begin
      addr_match[l] = (ack_address == match_reg[l]);
      internal_req[l] = pending_reg[l] && !in_service[l];
    end
    raw_match = soft_ack ? (3'h1 << soft_lvl_reg) : (hw_ack ? addr_match : 3'h0);
    eff_match = raw_match;
    if (automatic_priority_reg && raw_match != '0 && in_req != '0) begin
      if (in_req[0]) begin
        eff_match = 3'h1;
      end else if (in_req[1]) begin
        eff_match = 3'h2;
      end else begin
        eff_match = 3'h4;
      end
    end
    if (any_hold) begin
      eff_match = '0;
    end
    grant_lvl = grant[0] ? 2'h0 : (grant[1] ? 2'h1 : 2'h2);
    grant_type = pend_type_reg[grant_lvl];
  end

  genvar g;
  generate
    for (g = 0; g < NL; g++) begin : gen_level
      sra_level_fsm u_level (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .internal_req(internal_req[g]),
        .ack_active(ack_active),
        .match(eff_match[g]),
        .ext_req_n(ext_request_n[g]),
        .request_n(req_n[g]),
        .grant(grant[g]),
        .in_request(in_req[g]),
        .passing(passing[g]),
        .keeping(keeping[g])
      );
    end
  endgenerate

  // Register read multiplexer.
  always_comb begin
    rd_val = 32'h0;
    if (avs_address == sra_pkg::OFF_CONTROL) begin
      rd_val[sra_pkg::CTRL_AUTOMATIC_PRIORITY_BIT] = automatic_priority_reg;
    end else if (avs_address == sra_pkg::OFF_SERVICE_VECTOR) begin
      rd_val[7:0] = vec_now;
    end else if (match_hit != '0) begin
      rd_val[7:0] = match_reg[hit_idx];
    end else if (chan_hit != '0) begin
      rd_val[7:0] = chan_store_reg[hit_idx];
      rd_val[sra_pkg::CHAN_FIELD_MSB:sra_pkg::CHAN_FIELD_LSB] = active_channel;
    end else if (avs_address == sra_pkg::OFF_SERVICE_STATUS) begin
      for (int i = 0; i < SD; i++) begin
        rd_val[2*i +: 2] = (2'(i) < depth_reg) ? stk_lvl_reg[i] : sra_pkg::LVL_NONE;
      end
      rd_val[sra_pkg::STATUS_DEPTH_LSB +: 2] = depth_reg;
    end else if (avs_address == sra_pkg::OFF_CHANNEL_ACCESS) begin
      rd_val[2:0] = car_reg;
    end
  end

  // Bus sequencing, register writes, posting, stack and acknowledge answer.
  always_comb begin
    bus_next = bus_reg;
    rdata_next = rdata_reg;
    soft_lvl_next = soft_lvl_reg;
    automatic_priority_next = automatic_priority_reg;
    vec_upper_next = vec_upper_reg;
    match_next = match_reg;
    chan_store_next = chan_store_reg;
    car_next = car_reg;
    pending_next = pending_reg;
    pend_type_next = pend_type_reg;
    pend_chan_next = pend_chan_reg;
    stk_lvl_next = stk_lvl_reg;
    stk_type_next = stk_type_reg;
    stk_chan_next = stk_chan_reg;
    eos_pop = 1'b0;
    case (bus_reg)
      sra_pkg::BUS_IDLE: begin
        if (avs_read && ack_hit != '0) begin
          bus_next = sra_pkg::BUS_ACK;
          soft_lvl_next = hit_idx;
        end else if (avs_read || avs_write) begin
          bus_next = sra_pkg::BUS_DONE;
          rdata_next = rd_val;
        end
      end
      sra_pkg::BUS_ACK: begin
        bus_next = sra_pkg::BUS_DONE;
        rdata_next = (grant != '0) ? {24'h0, vec_upper_reg, pend_type_reg[grant_lvl]} : 32'h0;
      end
      sra_pkg::BUS_DONE: begin
        bus_next = sra_pkg::BUS_IDLE;
        if (avs_write && avs_byteenable[0]) begin
          if (avs_address == sra_pkg::OFF_CONTROL) begin
            automatic_priority_next = avs_writedata[sra_pkg::CTRL_AUTOMATIC_PRIORITY_BIT];
          end else if (avs_address == sra_pkg::OFF_SERVICE_VECTOR) begin
            vec_upper_next = avs_writedata[7:3];
          end else if (match_hit != '0) begin
            match_next[hit_idx] = avs_writedata[7:0];
          end else if (chan_hit != '0) begin
            chan_store_next[hit_idx] = avs_writedata[7:0];
          end else if (avs_address == sra_pkg::OFF_END_OF_SERVICE) begin
            eos_pop = 1'b1;
          end else if (avs_address == sra_pkg::OFF_CHANNEL_ACCESS) begin
            car_next = avs_writedata[2:0];
          end
        end
      end
      default: begin
        bus_next = sra_pkg::BUS_IDLE;
      end
    endcase
    if (post_valid && post_ready) begin
      pending_next[post_level] = 1'b1;
      pend_type_next[post_level] = post_type;
      pend_chan_next[post_level] = post_channel;
    end
    d = depth_reg;
    if (eos_pop && d != 2'h0) begin
      d = d - 2'h1;
    end
    if (grant != '0 && d != 2'(SD)) begin
      stk_lvl_next[d] = grant_lvl;
      stk_type_next[d] = pend_type_reg[grant_lvl];
      stk_chan_next[d] = pend_chan_reg[grant_lvl];
      pending_next[grant_lvl] = 1'b0;
      d = d + 2'h1;
    end
    depth_next = d;
    // vector onto the acknowledge data bus
    ack_data_next = vec_now;
    // strobe only for a kept level
    data_transfer_ack_n_n_next = !(hw_ack && keeping != '0);
  end

  // Registers of the slave, the posted requests and the stack.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bus_reg <= sra_pkg::BUS_IDLE;
      rdata_reg <= 32'h0;
      soft_lvl_reg <= 2'h0;
      automatic_priority_reg <= 1'b0;
      vec_upper_reg <= sra_pkg::VEC_UPPER_RESET;
      car_reg <= sra_pkg::CAR_RESET;
      pending_reg <= '0;
      depth_reg <= 2'h0;
      ack_data_reg <= 8'h00;
      data_transfer_ack_n_n_reg <= 1'b1;
      for (int l = 0; l < NL; l++) begin
        match_reg[l] <= sra_pkg::MATCH_RESET;
        chan_store_reg[l] <= sra_pkg::CHAN_STORE_RESET;
        pend_type_reg[l] <= 3'h0;
        pend_chan_reg[l] <= 3'h0;
      end
      for (int i = 0; i < SD; i++) begin
        stk_lvl_reg[i] <= 2'h0;
        stk_type_reg[i] <= 3'h0;
        stk_chan_reg[i] <= 3'h0;
      end
    end else begin
      bus_reg <= bus_next;
      rdata_reg <= rdata_next;
      soft_lvl_reg <= soft_lvl_next;
      automatic_priority_reg <= automatic_priority_next;
      vec_upper_reg <= vec_upper_next;
      car_reg <= car_next;
      pending_reg <= pending_next;
      depth_reg <= depth_next;
      ack_data_reg <= ack_data_next;
      data_transfer_ack_n_n_reg <= data_transfer_ack_n_n_next;
      match_reg <= match_next;
      chan_store_reg <= chan_store_next;
      pend_type_reg <= pend_type_next;
      pend_chan_reg <= pend_chan_next;
      stk_lvl_reg <= stk_lvl_next;
      stk_type_reg <= stk_type_next;
      stk_chan_reg <= stk_chan_next;
    end
  end

  // Output pins; the chain output is held off while any level keeps.
  assign avs_waitrequest = (bus_reg != sra_pkg::BUS_DONE);
  assign avs_readdata = rdata_reg;
  assign post_ready = (post_level != sra_pkg::LVL_NONE) && !pending_reg[post_level];
  assign receive_service_request_n = req_n[sra_pkg::LVL_RX];
  assign transmit_service_request_n = req_n[sra_pkg::LVL_TX];
  assign modem_change_request_n = req_n[sra_pkg::LVL_MODEM];
  assign chain_ack_out_n = !((passing != '0) && (keeping == '0));
  assign data_transfer_ack_n = data_transfer_ack_n_n_reg;
  assign ack_data = ack_data_reg;

  chk_eos_reassert: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (eos_pop && depth_reg == 2'h1 && pending_reg == 3'h1 && in_req == '0 && chain_ack_in_n)
    |-> ##(sra_pkg::EOS_REASSERT_CYCLES + 1) !req_n[0]) else $error("request not back two clocks after pop");
  chk_push_record: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (grant != '0 && !eos_pop) |=> depth_reg == $past(depth_reg) + 2'h1
    && stk_lvl_reg[depth_reg - 2'h1] == $past(grant_lvl)) else $error("grant not pushed on stack");
  chk_vector_out: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (grant != '0 && !eos_pop) |=> ##1 ack_data == {vec_upper_reg, $past(grant_type, 2)})
    else $error("wrong vector on ack data");
  chk_no_match_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (hw_ack && addr_match == '0 && !any_hold && bus_reg != sra_pkg::BUS_ACK && !automatic_priority_reg)
    |=> data_transfer_ack_n && chain_ack_out_n) else $error("unmatched acknowledge answered");
  chk_chan_readback: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (bus_reg == sra_pkg::BUS_IDLE && avs_read && chan_hit != '0)
    |=> avs_readdata[4:2] == $past(active_channel)) else $error("channel field not masked in");
  chk_automatic_priority_pick: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (automatic_priority_reg && hw_ack && addr_match != '0 && in_req != '0 && !any_hold)
    |=> ($past(in_req[0]) ? keeping[0] : ($past(in_req[1]) ? keeping[1] : keeping[2])))
    else $error("highest priority level not chosen");
  cov_nested_three: cover property (@(posedge ref_clk) depth_reg == 2'h3);
  cov_chain_pass: cover property (@(posedge ref_clk) !chain_ack_out_n);
  cov_soft_grant: cover property (@(posedge ref_clk) soft_ack && grant != '0);
endmodule

// ===== pkg/sra_pkg.sv
// Constants, register map and state types of the service request and acknowledge logic.
package sra_pkg;
  // Request levels, also the level codes held on the service context stack.
  localparam int NUM_LEVELS = 3;
  localparam logic [1:0] LVL_RX = 2'h0;
  localparam logic [1:0] LVL_TX = 2'h1;
  localparam logic [1:0] LVL_MODEM = 2'h2;
  localparam logic [1:0] LVL_NONE = 2'h3;
  localparam int STACK_DEPTH = 3;
  localparam int TYPE_W = 3;
  localparam int CHAN_W = 3;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_SERVICE_VECTOR = 8'h04;
  localparam logic [7:0] OFF_MATCH_BASE = 8'h08;
  localparam logic [7:0] OFF_ACK_BASE = 8'h14;
  localparam logic [7:0] OFF_END_OF_SERVICE = 8'h20;
  localparam logic [7:0] OFF_CHANNEL_BASE = 8'h24;
  localparam logic [7:0] OFF_SERVICE_STATUS = 8'h30;
  localparam logic [7:0] OFF_CHANNEL_ACCESS = 8'h34;
  localparam logic [7:0] OFF_STRIDE = 8'h04;

  // Field positions.
  localparam int CTRL_AUTOMATIC_PRIORITY_BIT = 0;
  localparam int CHAN_FIELD_LSB = 2;
  localparam int CHAN_FIELD_MSB = 4;
  localparam int STATUS_DEPTH_LSB = 8;

  // Reset values.
  localparam logic [7:0] MATCH_RESET = 8'h00;
  localparam logic [7:0] CHAN_STORE_RESET = 8'h00;
  localparam logic [4:0] VEC_UPPER_RESET = 5'h00;
  localparam logic [2:0] CAR_RESET = 3'h0;

  // Clock periods from the end-of-service write to the request reappearing.
  localparam int EOS_REASSERT_CYCLES = 2;

  // Per-level acknowledge state machine.
  typedef enum logic [1:0] {LVL_IDLE, LVL_REQ_ACTIVE, LVL_PASS_ACK, LVL_KEEP_ACK} sra_lvl_state_t;
  // Bus slave sequencing.
  typedef enum logic [1:0] {BUS_IDLE, BUS_ACK, BUS_DONE} sra_bus_state_t;
endpackage

// ===== rtl/sra_level_fsm.sv
// One service request level: request, pass or keep of an acknowledge, and the shared-line hold.
`timescale 1ns/1ns
module sra_level_fsm (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic internal_req,
  input wire logic ack_active,
  input wire logic match,
  input wire logic ext_req_n,
  output logic request_n,
  output logic grant,
  output logic in_request,
  output logic passing,
  output logic keeping
);
  sra_pkg::sra_lvl_state_t state_reg, state_next;
  logic block_reg, block_next;
  logic req_n_reg, req_n_next;

  // Next state of the level machine and of the hold on the shared request line.
  always_comb begin
    state_next = state_reg;
    block_next = block_reg;
    if (block_reg && ext_req_n) begin
      block_next = 1'b0;
    end
    case (state_reg)
      sra_pkg::LVL_IDLE: begin
        if (internal_req && !block_reg) begin
          state_next = sra_pkg::LVL_REQ_ACTIVE;
        end else if (ack_active && match) begin
          state_next = sra_pkg::LVL_PASS_ACK;
        end
      end
      sra_pkg::LVL_REQ_ACTIVE: begin
        if (ack_active && match) begin
          state_next = sra_pkg::LVL_KEEP_ACK;
        end
      end
      sra_pkg::LVL_PASS_ACK: begin
        if (!ack_active) begin
          state_next = sra_pkg::LVL_IDLE;
        end
      end
      sra_pkg::LVL_KEEP_ACK: begin
        if (!ack_active) begin
          state_next = sra_pkg::LVL_IDLE;
          // hold while line driven elsewhere
          // The shared line is low only because of another device once our own pin is high.
          if (!ext_req_n && req_n_reg) begin
            block_next = 1'b1;
          end
        end
      end
      default: begin
        state_next = sra_pkg::LVL_IDLE;
      end
    endcase
    req_n_next = (state_reg != sra_pkg::LVL_REQ_ACTIVE);
  end

  // Registers of the level machine.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= sra_pkg::LVL_IDLE;
      block_reg <= 1'b0;
      req_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      block_reg <= block_next;
      req_n_reg <= req_n_next;
    end
  end

  assign request_n = req_n_reg;
  assign grant = (state_reg == sra_pkg::LVL_REQ_ACTIVE) && ack_active && match;
  assign in_request = (state_reg == sra_pkg::LVL_REQ_ACTIVE);
  assign passing = (state_reg == sra_pkg::LVL_PASS_ACK);
  assign keeping = (state_reg == sra_pkg::LVL_KEEP_ACK);

  chk_request_pin: assert property (@(posedge ref_clk) disable iff (sys_rst)
    in_request |=> !request_n) else $error("request pin not asserted in request state");
  chk_keep_negates: assert property (@(posedge ref_clk) disable iff (sys_rst)
    grant |=> keeping ##1 request_n) else $error("grant did not keep and negate request");
  chk_pass_on_match: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_reg == sra_pkg::LVL_IDLE && !internal_req && ack_active && match) |=> passing)
    else $error("idle level did not pass matching acknowledge");
  chk_idle_no_match: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_reg == sra_pkg::LVL_IDLE && !internal_req && !match) |=> !passing && !keeping)
    else $error("idle level acted without a match");
  chk_hold_while_ack: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ((passing || keeping) && ack_active) |=> $stable(state_reg)) else $error("left ack state early");
  chk_shared_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (keeping && !ack_active && !ext_req_n && request_n) |=> (state_reg == sra_pkg::LVL_IDLE) ##1 !in_request)
    else $error("request reasserted while shared line active");
endmodule

// ===== tb/sra_host_model.sv
// Host model: interrupt controller that runs hardware acknowledge cycles.
`timescale 1ns/1ns
module sra_host_model (
  input wire logic ref_clk,
  input wire logic data_transfer_ack_n,
  input wire logic chain_ack_out_n,
  output logic chain_ack_in_n,
  output logic [7:0] ack_address
);
  // The acknowledge is idle at time zero.
  initial begin
    chain_ack_in_n = 1'b1;
    ack_address = 8'h5A;
  end

  // Runs one acknowledge cycle and reports whether it was taken or passed on.
  task automatic ack_cycle(input logic [7:0] a, input int hold, output logic taken, output logic passed);
    taken = 1'b0;
    passed = 1'b0;
    @(posedge ref_clk);
    ack_address <= a;
    chain_ack_in_n <= 1'b0;
    for (int i = 0; i < 8 && !taken; i++) begin
      @(posedge ref_clk);
      taken = !data_transfer_ack_n;
      passed = passed | !chain_ack_out_n;
    end
    repeat (hold) @(posedge ref_clk);
    chain_ack_in_n <= 1'b1;
    ack_address <= ~a;
    repeat (2) @(posedge ref_clk);
  endtask
endmodule

// ===== tb/testbench.sv
// Self-checking testbench of the service request and acknowledge logic.
`timescale 1ns/1ns
`define CHK(got, exp) check_val(got, exp)
module testbench;
  localparam logic [7:0] EOS = sra_pkg::OFF_END_OF_SERVICE;
  localparam logic [7:0] STAT = sra_pkg::OFF_SERVICE_STATUS;
  logic ref_clk, sys_rst, avs_read, avs_write, avs_waitrequest, post_valid, post_ready;
  logic [7:0] avs_address, ack_address, ack_data, base, store;
  logic [31:0] avs_writedata, avs_readdata;
  logic [1:0] post_level;
  logic [2:0] post_type, post_channel, other_n, channel_access_register, act_ch;
  logic chain_ack_in_n, chain_ack_out_n, data_transfer_ack_n, dt_prev, taken, passed;
  logic [4:0] upper;
  logic [2:0] ty [0:7];
  logic [2:0] ch [0:7];
  wire [2:0] req_n;
  logic [31:0] exp_q [$];
  int err_total, n_compared;

  sra_service_request i_dut (.ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .post_valid, .post_level, .post_type,
    .post_channel, .post_ready, .receive_service_request_n(req_n[0]), .transmit_service_request_n(req_n[1]),
    .modem_change_request_n(req_n[2]), .ext_request_n(req_n & other_n), .chain_ack_in_n, .ack_address,
    .chain_ack_out_n, .data_transfer_ack_n, .ack_data, .active_channel(act_ch));
  sra_host_model i_host (.ref_clk, .data_transfer_ack_n, .chain_ack_out_n, .chain_ack_in_n, .ack_address);

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Compared %0d, mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic timed_out();
    err_total++;
    $display("wrong value at %0t: wait ran out", $time);
    report_and_stop();
  endtask

  // Avalon-MM access held until waitrequest is low; a read notes its expected data.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    if (!wr) exp_q.push_back(d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 20) timed_out();
  endtask

  // Posts an internal request and holds it until it is taken.
  task automatic post(input logic [1:0] lvl, input int k);
    int i;
    @(posedge ref_clk);
    post_valid <= 1'b1;
    post_level <= lvl;
    post_type <= ty[k];
    post_channel <= ch[k];
    for (i = 0; i < 40; i++) begin
      @(posedge ref_clk);
      if (post_ready === 1'b1) break;
    end
    post_valid <= 1'b0;
    if (i == 40) timed_out();
  endtask

  // Hardware acknowledge at match value base plus lvl; a taken cycle notes its vector.
  task automatic hw_ack(input logic [1:0] lvl, input int k, input logic dt, input logic ps);
    if (dt) exp_q.push_back({24'h0, upper, ty[k]});
    i_host.ack_cycle(base | 8'(lvl), $urandom_range(0, 3), taken, passed);
    `CHK(taken, dt);
    `CHK(passed, ps);
  endtask

  task automatic pins(input logic [2:0] e);
    @(posedge ref_clk);
    #1;
    `CHK(req_n, e);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge ref_clk);
    timed_out();
  end

  // Compares each read answer and each acknowledge vector with the oldest note.
  always @(posedge ref_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) `CHK(avs_readdata, exp_q.pop_front());
    if (data_transfer_ack_n === 1'b0 && dt_prev !== 1'b0) `CHK({24'h0, ack_data}, exp_q.pop_front());
    dt_prev <= data_transfer_ack_n;
  end

  // Main sequence.
  initial begin
    err_total = 0;
    n_compared = 0;
    sys_rst = 1'b1;
    {avs_read, avs_write, post_valid, avs_address, avs_writedata} = '0;
    {post_level, post_type, post_channel} = '0;
    other_n = 3'h7;
    void'($urandom(32'h2A35FCAB));
    base = 8'($urandom()) & 8'hFC;
    upper = 5'($urandom());
    store = 8'($urandom());
    channel_access_register = 3'($urandom());
    for (int k = 0; k < 8; k++) begin
      ty[k] = 3'($urandom_range(0, 3));
      ch[k] = 3'($urandom_range(0, 7));
    end
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    pins(3'h7);
    `CHK(chain_ack_out_n, 1'b1);
    for (int k = 0; k < 3; k++) bus(1'b1, sra_pkg::OFF_MATCH_BASE + 8'(4 * k), {24'h0, base | 8'(k)});
    bus(1'b1, sra_pkg::OFF_SERVICE_VECTOR, {24'h0, upper, 3'h0});
    bus(1'b1, sra_pkg::OFF_CHANNEL_BASE, {24'h0, store});
    bus(1'b0, sra_pkg::OFF_MATCH_BASE + 8'h04, {24'h0, base | 8'h01});
    bus(1'b0, 8'hFC, 32'h0);
    post(sra_pkg::LVL_RX, 0);
    post(sra_pkg::LVL_TX, 1);
    repeat (2) @(posedge ref_clk);
    pins(3'h4);
    hw_ack(2'h0, 0, 1'b1, 1'b0);
    pins(3'h5);
    `CHK(act_ch, ch[0]);
    bus(1'b0, STAT, 32'h13C);
    bus(1'b0, sra_pkg::OFF_CHANNEL_BASE, {24'h0, store[7:5], ch[0], store[1:0]});
    bus(1'b0, sra_pkg::OFF_ACK_BASE + 8'h04, {24'h0, upper, ty[1]});
    post(sra_pkg::LVL_MODEM, 2);
    repeat (2) @(posedge ref_clk);
    bus(1'b0, sra_pkg::OFF_ACK_BASE + 8'h08, {24'h0, upper, ty[2]});
    bus(1'b0, STAT, 32'h324);
    post(sra_pkg::LVL_RX, 3);
    bus(1'b1, EOS, 32'h0);
    bus(1'b1, EOS, 32'h0);
    bus(1'b0, STAT, 32'h13C);
    bus(1'b1, EOS, 32'h0);
    pins(3'h7);
    pins(3'h6);
    bus(1'b0, STAT, 32'h03F);
    bus(1'b1, sra_pkg::OFF_CHANNEL_ACCESS, {29'h0, channel_access_register});
    bus(1'b0, sra_pkg::OFF_CHANNEL_BASE + 8'h04, {27'h0, channel_access_register, 2'h0});
    hw_ack(2'h0, 3, 1'b1, 1'b0);
    bus(1'b1, EOS, 32'h0);
    hw_ack(2'h3, 0, 1'b0, 1'b0);
    hw_ack(2'h1, 0, 1'b0, 1'b1);
    bus(1'b1, sra_pkg::OFF_CONTROL, 32'h1);
    post(sra_pkg::LVL_TX, 4);
    post(sra_pkg::LVL_MODEM, 5);
    repeat (2) @(posedge ref_clk);
    hw_ack(2'h2, 4, 1'b1, 1'b0);
    bus(1'b1, EOS, 32'h0);
    hw_ack(2'h2, 5, 1'b1, 1'b0);
    bus(1'b1, EOS, 32'h0);
    bus(1'b1, sra_pkg::OFF_CONTROL, 32'h0);
    other_n <= 3'h6;
    post(sra_pkg::LVL_RX, 6);
    repeat (2) @(posedge ref_clk);
    hw_ack(2'h0, 6, 1'b1, 1'b0);
    bus(1'b1, EOS, 32'h0);
    fork
      post(sra_pkg::LVL_RX, 7);
      begin
        repeat (6) pins(3'h7);
        other_n <= 3'h7;
      end
    join
    for (int k = 0; k < 20 && req_n[0] !== 1'b0; k++) @(posedge ref_clk);
    if (req_n[0] !== 1'b0) timed_out();
    pins(3'h6);
    report_and_stop();
  end
endmodule
